// ### verif/ccp_core_tb.sv
// Purpose: Self-checking bench for the power mode and measurement core
// Assumes: Shortened periods, AXI4-Lite master tasks
// Notes: Ready and valid are sampled on the falling edge, acted on at the rising one
`timescale 1ns/1ps
module ccp_core_tb;
  import ccp_pkg::*;
  localparam logic [63:0] ADDR64 = 64'hA5C3_1E2D_4B6F_7081; // Arbitrary value
  logic aclk, aresetn;
  logic [9:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic host_low, host_speed, speed_select, overdrive_timing;
  logic bus_data_in, bus_drive_low, bus_data_out, bus_data_oe;
  logic prog_io_pin_in, prog_io_pin_out, prog_io_pin_oe, undervoltage, active_mode;
  logic signed [15:0] sense_sample;
  int n_fail, samples_checked;

  ccp_core #(.HIGH_RES(1'b1), .SAMPLE_CNT(8), .CONV_CNT(40), .SLEEP_CNT(100),
    .NET_ADDR(ADDR64)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .speed_select(speed_select), .overdrive_timing(overdrive_timing),
    .bus_data_in(bus_data_in), .bus_drive_low(bus_drive_low), .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe), .prog_io_pin_in(prog_io_pin_in),
    .prog_io_pin_out(prog_io_pin_out), .prog_io_pin_oe(prog_io_pin_oe),
    .undervoltage(undervoltage), .sense_sample(sense_sample), .active_mode(active_mode));

  ccp_line_model u_line (.host_low(host_low), .host_speed(host_speed),
    .bus_data_oe(bus_data_oe), .prog_io_pin_oe(prog_io_pin_oe),
    .bus_data_in(bus_data_in), .prog_io_pin_in(prog_io_pin_in),
    .speed_select(speed_select));

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write one word; waits are bounded by the watchdog alone
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  // Read one word and compare data and response
  task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    logic a, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge aclk);
      a = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // Hang guard well beyond the several hundred cycles the sequence needs
  initial begin
    #100000;
    n_fail++;
    conclude();
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    host_low = 1'b0;
    host_speed = 1'b0;
    bus_drive_low = 1'b0;
    undervoltage = 1'b0;
    sense_sample = 16'sh0000;
    cyc(5);
    aresetn <= 1'b1;
    // Line high and supply fine wakes the device
    cyc(3);
    @(negedge aclk);
    chk("active", 32'h1, {31'h0, active_mode});
    rd(IDX_STATUS, 32'h0000_0000, RESP_OKAY);
    rd(IDX_SPECIAL, 32'h0000_0040, RESP_OKAY);
    rd(IDX_ADDR_LO, ADDR64[31:0], RESP_OKAY);
    rd(IDX_ADDR_HI, ADDR64[63:32], RESP_OKAY);
    rd(8'h00, 32'h0000_0000, RESP_SLVERR);
    wr(IDX_CURRENT, 32'h0000_1111, RESP_SLVERR);
    wr(IDX_STATUS, 32'h0000_0050, RESP_OKAY);
    rd(IDX_STATUS, 32'h0000_0050, RESP_OKAY);
    // Speed strap both ways
    host_speed <= 1'b1;
    cyc(2);
    @(negedge aclk);
    chk("overdrive", 32'h1, {31'h0, overdrive_timing});
    rd(IDX_MODE, 32'h0000_0003, RESP_OKAY);
    host_speed <= 1'b0;
    cyc(2);
    @(negedge aclk);
    chk("overdrive", 32'h0, {31'h0, overdrive_timing});
    // Line driver only ever pulls low
    @(posedge aclk);
    bus_drive_low <= 1'b1;
    cyc(2);
    @(negedge aclk);
    chk("line_oe", 32'h1, {31'h0, bus_data_oe});
    chk("line_out", 32'h0, {31'h0, bus_data_out});
    @(posedge aclk);
    bus_drive_low <= 1'b0;
    // Pin driven low by the control bit, level read back
    wr(IDX_SPECIAL, 32'h0000_0000, RESP_OKAY);
    cyc(2);
    @(negedge aclk);
    chk("pin_oe", 32'h1, {31'h0, prog_io_pin_oe});
    chk("pin_out", 32'h0, {31'h0, prog_io_pin_out});
    rd(IDX_SPECIAL, 32'h0000_0000, RESP_OKAY);
    // Negative full scale: clipped, one accumulation, then undervoltage sleep
    sense_sample <= 16'sh8000;
    cyc(20);
    wr(IDX_ACCUM, 32'h0000_0000, RESP_OKAY);
    cyc(100);
    undervoltage <= 1'b1;
    cyc(3);
    @(negedge aclk);
    chk("active", 32'h0, {31'h0, active_mode});
    chk("pin_oe", 32'h0, {31'h0, prog_io_pin_oe});
    rd(IDX_CURRENT, 32'h0000_8001, RESP_OKAY);
    rd(IDX_ACCUM, 32'h0000_FFF8, RESP_OKAY);
    cyc(200);
    rd(IDX_CURRENT, 32'h0000_8001, RESP_OKAY);
    rd(IDX_ACCUM, 32'h0000_FFF8, RESP_OKAY);
    @(negedge aclk);
    chk("active", 32'h0, {31'h0, active_mode});
    @(posedge aclk);
    undervoltage <= 1'b0;
    cyc(3);
    @(negedge aclk);
    chk("active", 32'h1, {31'h0, active_mode});
    // Long low line with sleep disallowed keeps the mode, still releases the pin
    wr(IDX_STATUS, 32'h0000_0000, RESP_OKAY);
    wr(IDX_SPECIAL, 32'h0000_0000, RESP_OKAY);
    host_low <= 1'b1;
    cyc(150);
    @(negedge aclk);
    chk("active", 32'h1, {31'h0, active_mode});
    chk("pin_oe", 32'h0, {31'h0, prog_io_pin_oe});
    @(posedge aclk);
    host_low <= 1'b0;
    // Interrupted low spells restart the timer, an unbroken one sleeps
    wr(IDX_STATUS, 32'h0000_0040, RESP_OKAY);
    host_low <= 1'b1;
    cyc(60);
    host_low <= 1'b0;
    cyc(5);
    host_low <= 1'b1;
    cyc(60);
    @(negedge aclk);
    chk("active", 32'h1, {31'h0, active_mode});
    cyc(50);
    @(negedge aclk);
    chk("active", 32'h0, {31'h0, active_mode});
    @(posedge aclk);
    host_low <= 1'b0;
    cyc(3);
    @(negedge aclk);
    chk("active", 32'h1, {31'h0, active_mode});
    conclude();
  end
endmodule

// ### verif/ccp_line_model.sv
// Purpose: Far-side model of the single-wire line, the pin pull-up and the speed strap
// Assumes: Host pull-up on the line, external pull-up on the programmable pin
// Notes: Wired-AND levels, so a released line always reads high
`timescale 1ns/1ps
module ccp_line_model (
  input wire logic host_low,
  input wire logic host_speed,
  input wire logic bus_data_oe,
  input wire logic prog_io_pin_oe,
  output logic bus_data_in,
  output logic prog_io_pin_in,
  output logic speed_select
);
  // Either party pulling low wins; nobody ever drives high
  assign bus_data_in = !(host_low || bus_data_oe);
  assign prog_io_pin_in = !prog_io_pin_oe;
  // One strap shared by every device on the bus
  assign speed_select = host_speed;
endmodule

// ### verilog/ccp_core.sv
// Purpose: Power mode control, current conversion and accumulation, register file
// Assumes: Pins synchronous to aclk, supply adequate for access in sleep
// Notes: Long periods are parameters so a simulation can shorten them
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module ccp_core
  import ccp_pkg::*;
#(
  parameter bit HIGH_RES = 1'b1,
  parameter int SAMPLE_CNT = SAMPLE_CYCLES,
  parameter int CONV_CNT = HIGH_RES ? CONV_HI_CYCLES : CONV_LO_CYCLES,
  parameter int SLEEP_CNT = SLEEP_LOW_CYCLES,
  parameter logic [63:0] NET_ADDR = 64'h0123_4567_89AB_CDEF // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic speed_select,
  output logic overdrive_timing,
  input wire logic bus_data_in,
  input wire logic bus_drive_low,
  output logic bus_data_out,
  output logic bus_data_oe,
  input wire logic prog_io_pin_in,
  output logic prog_io_pin_out,
  output logic prog_io_pin_oe,
  input wire logic undervoltage,
  input wire logic signed [15:0] sense_sample,
  output logic active_mode
);
  ccp_mode_t mode_r, mode_nxt;
  logic uv_prev_r;
  logic sleep_allow_r, net_opcode_r, pio_ctl_r;
  logic signed [15:0] sample_r, current_r;
  logic [ACC_W-1:0] acc_r;
  logic skip_r;
  logic [7:0] aw_idx_r;
  logic aw_held_r, w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic sample_tick, conv_tick, low_tick;

  // Mode transitions: undervoltage level and its falling edge first, then line activity
  wire uv_rise_w = undervoltage && !uv_prev_r;
  wire uv_fall_w = !undervoltage && uv_prev_r;
  wire active_w = (mode_r == CCP_ACTIVE);
  wire line_sleep_w = low_tick && sleep_allow_r; // [R14] [R16]
  always_comb begin
    mode_nxt = mode_r;
    if (undervoltage) begin
      mode_nxt = CCP_SLEEP; // [R13]
    end else if (uv_fall_w) begin
      mode_nxt = CCP_ACTIVE; // [R12]
    end else if (!active_w && bus_data_in) begin
      mode_nxt = CCP_ACTIVE; // [R11]
    end else if (active_w && line_sleep_w) begin
      mode_nxt = CCP_SLEEP;
    end
  end
  wire enter_sleep_w = active_w && (mode_nxt == CCP_SLEEP);

  // Write channel decode; ahead of the conversion divider, which clears on an ACR write
  wire wr_go_w = aw_held_r && w_held_r && !s_axi_bvalid;
  wire sta_wr_w = wr_go_w && (aw_idx_r == IDX_STATUS) && wstrb_r[0];
  wire spc_wr_w = wr_go_w && (aw_idx_r == IDX_SPECIAL) && wstrb_r[0];
  wire acc_wr_w = wr_go_w && (aw_idx_r == IDX_ACCUM) && (wstrb_r[1:0] != 2'h0);
  wire wr_ok_w = (aw_idx_r == IDX_STATUS) || (aw_idx_r == IDX_SPECIAL) ||
    (aw_idx_r == IDX_ACCUM);

  // Timebase dividers; conversion cleared in sleep so a partial one is dropped
  ccp_tick_div #(.PERIOD(SAMPLE_CNT)) u_sample (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(!active_w),
    .run(1'b1),
    .tick(sample_tick)
  ); // [R15]
  ccp_tick_div #(.PERIOD(CONV_CNT)) u_conv (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(!active_w || enter_sleep_w || acc_wr_w),
    .run(1'b1),
    .tick(conv_tick)
  ); // [R17] [R20]
  ccp_tick_div #(.PERIOD(SLEEP_CNT)) u_low (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(bus_data_in || !active_w),
    .run(1'b1),
    .tick(low_tick)
  ); // [R19]

  // Current clip to variant magnitude
  wire [15:0] cmax_w = HIGH_RES ? CUR_MAX_HI : CUR_MAX_LO;
  wire signed [15:0] cpos_w = $signed(cmax_w);
  wire signed [15:0] cneg_w = -cpos_w;
  wire signed [15:0] clip_w = (sample_r > cpos_w) ? cpos_w :
    (sample_r < cneg_w) ? cneg_w : sample_r; // [R7]
  wire conv_upd_w = conv_tick && active_w && !skip_r;
  wire [ACC_W-1:0] acc_add_w = acc_r + ACC_W'($signed(clip_w)); // [R6]
  wire [15:0] acc_wval_w = {wstrb_r[1] ? wdata_r[15:8] : acc_r[ACC_W-1 -: 8],
    wstrb_r[0] ? wdata_r[7:0] : acc_r[ACC_W-9 -: 8]};

  // Mode and undervoltage history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= CCP_SLEEP;
      uv_prev_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      uv_prev_r <= undervoltage;
    end
  end

  // Status and pin control; sleep entry releases the pin driver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_allow_r <= SLEEP_ALLOW_RST;
      net_opcode_r <= NET_OPCODE_RST;
      pio_ctl_r <= PIO_CTL_RST;
    end else begin
      if (sta_wr_w) begin
        sleep_allow_r <= wdata_r[BIT_SLEEP_ALLOW];
        net_opcode_r <= wdata_r[BIT_NET_OPCODE];
      end
      if (enter_sleep_w || low_tick) begin
        pio_ctl_r <= PIO_CTL_RST; // [R18]
      end else if (spc_wr_w) begin
        pio_ctl_r <= wdata_r[BIT_PIO_CTL];
      end
    end
  end

  // Sampling, conversion result and accumulation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_r <= '0;
      current_r <= '0;
      acc_r <= '0;
      skip_r <= 1'b0;
    end else begin
      if (sample_tick) begin
        sample_r <= sense_sample; // [R15]
      end
      if (conv_upd_w) begin
        current_r <= clip_w; // [R8]
      end
      // Host write wins and clears the hidden fraction
      if (acc_wr_w) begin
        acc_r <= {acc_wval_w, {ACC_FRAC{1'b0}}};
      end else if (conv_upd_w) begin
        acc_r <= acc_add_w; // [R17]
      end
      // First conversion after an accumulator write is an offset pass
      if (acc_wr_w) begin
        skip_r <= 1'b1;
      end else if (conv_tick) begin
        skip_r <= 1'b0;
      end
    end
  end

  // Pins: both open-drain, drive only low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_data_out <= 1'b0;
      bus_data_oe <= 1'b0;
      prog_io_pin_out <= 1'b0;
      prog_io_pin_oe <= 1'b0;
      overdrive_timing <= 1'b0;
      active_mode <= 1'b0;
    end else begin
      bus_data_out <= 1'b0;
      bus_data_oe <= bus_drive_low; // [R4]
      prog_io_pin_out <= 1'b0;
      prog_io_pin_oe <= !pio_ctl_r; // [R3] [R9]
      overdrive_timing <= speed_select; // [R1]
      active_mode <= (mode_nxt == CCP_ACTIVE);
    end
  end

  // AXI write: address and data taken in either order, one response each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go_w) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok_w ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;

  // Read decode; registers stay readable in both modes
  wire [7:0] ar_idx_w = s_axi_araddr[9:2];
  wire [31:0] rd_status_w = {24'h000000, 1'b0, sleep_allow_r, 1'b0, net_opcode_r, 4'h0};
  wire [31:0] rd_special_w = {25'h0000000, prog_io_pin_in, 6'h00};
  wire [31:0] rd_mode_w = {30'h0, overdrive_timing, active_w};
  wire rd_ok_w = (ar_idx_w == IDX_STATUS) || (ar_idx_w == IDX_SPECIAL) ||
    (ar_idx_w == IDX_CURRENT) || (ar_idx_w == IDX_ACCUM) ||
    (ar_idx_w == IDX_ADDR_LO) || (ar_idx_w == IDX_ADDR_HI) || (ar_idx_w == IDX_MODE);
  wire [31:0] rd_val_w =
    (ar_idx_w == IDX_STATUS) ? rd_status_w :
    (ar_idx_w == IDX_SPECIAL) ? rd_special_w :
    (ar_idx_w == IDX_CURRENT) ? {16'h0, current_r} :
    (ar_idx_w == IDX_ACCUM) ? {16'h0, acc_r[ACC_W-1 -: 16]} :
    (ar_idx_w == IDX_ADDR_LO) ? NET_ADDR[31:0] : // [R5]
    (ar_idx_w == IDX_ADDR_HI) ? NET_ADDR[63:32] :
    (ar_idx_w == IDX_MODE) ? rd_mode_w : 32'h0;

  // AXI read: one outstanding, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val_w; // [R9] [R10]
      s_axi_rresp <= rd_ok_w ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_going_to_sleep;
    active_w ##1 !active_w;
  endsequence

  a_uv_forces_sleep: assert property (undervoltage |=> !active_w) // [R13]
    else $error("undervoltage did not force sleep");
  a_uv_clear_wakes: assert property (uv_fall_w |=> active_w) // [R12]
    else $error("undervoltage clear did not wake");
  a_line_high_wakes: assert property (!active_w && bus_data_in && !undervoltage |=> active_w) // [R11]
    else $error("high line did not wake");
  a_sleep_gate_off: assert property (active_w && !sleep_allow_r && !undervoltage |=> active_w) // [R16]
    else $error("sleep without sleep-allow");
  a_pio_on_sleep: assert property (s_going_to_sleep |-> pio_ctl_r) // [R18]
    else $error("pin control not released on sleep");
  a_sleep_frozen: assert property (!active_w && !acc_wr_w |=> $stable(acc_r) && $stable(current_r)) // [R10] [R20]
    else $error("measurement moved in sleep");
  a_conv_update: assert property (conv_upd_w |=> current_r == $past(clip_w)) // [R8] [R15]
    else $error("current not updated at conversion end");
  a_current_range: assert property (current_r <= cpos_w && current_r >= cneg_w) // [R7]
    else $error("current outside variant range");
  a_pio_drive: assert property (!pio_ctl_r ##1 !pio_ctl_r |-> prog_io_pin_oe && !prog_io_pin_out) // [R3]
    else $error("pin not driven low");
  a_speed_follow: assert property (speed_select |=> overdrive_timing) // [R1]
    else $error("speed select not followed");
  a_bus_low_only: assert property (bus_data_oe |-> !bus_data_out) // [R4]
    else $error("bus driven high");

  // Line timer and accumulation steps
  a_line_sleep_entry: assert property (active_w && line_sleep_w && !undervoltage |=> !active_w) // [R14]
    else $error("expired low line did not sleep");
  a_low_pin_release: assert property (low_tick |=> pio_ctl_r) // [R18]
    else $error("pin control not released on low line");
  a_low_restart: assert property (bus_data_in |=> !low_tick) // [R19]
    else $error("low line timer did not restart");
  a_acc_step: assert property (conv_upd_w && !acc_wr_w |=> acc_r == $past(acc_r) + ACC_W'($past(clip_w))) // [R6]
    else $error("accumulator step wrong");
endmodule

// ### verilog/ccp_pkg.sv
// Purpose: Shared constants for the coulomb counter power and measurement control
// Assumes: 200 MHz aclk, AXI4-Lite register access, word per register
// Notes: Register byte address is four times the register index
// Functional notes
// R1: Speed select pin 1 gives overdrive timing, 0 standard timing.
// R2: Host keeps every device on one bus at the same speed.
// R3: Programmable pin is input or open-drain output set by a register bit.
// R4: Bus data pin receives levels and only ever drives low.
// R5: Device holds a unique 64-bit net address readable by the host.
// R6: Signed net current accumulates in a separate 16-bit register.
// R7: Current is signed, 15 bits magnitude high-res, 13 bits low-res.
// R8: In active mode measurement and accumulation run and update registers.
// R9: In active mode all registers are accessible and the pin works.
// R10: In sleep measurement halts but register access stays available.
// R11: Sleep ends when bus line is high and supply is not undervoltage.
// R12: Undervoltage clearing always wakes the device.
// R13: Undervoltage asserting always puts the device to sleep.
// R14: Sleep-allow set and bus line low for 2s gives sleep.
// R15: Sense inputs sampled at 18.6kHz; current updates each conversion end. Code skips the update at the first conversion end after an accumulator write.
// R16: Sleep-allow is status bit 6, resets to 0, blocks line sleep.
// R17: Conversion period 3.515s high-res, 0.878s low-res; accumulate at end.
// R18: Pin control bit resets to 1 at power-up and on sleep entry.
// R19: Low-line timer restarts from zero when the line returns high.
// R20: Entering sleep abandons the running conversion without updates.
package ccp_pkg;
  // Clock and timing
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_KHZ = CLK_HZ / 1000;
  localparam int SAMPLE_HZ = 18600;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam int CONV_HI_MS = 3515;
  localparam int CONV_LO_MS = 878;
  localparam int CONV_HI_CYCLES = CLK_KHZ * CONV_HI_MS;
  localparam int CONV_LO_CYCLES = CLK_KHZ * CONV_LO_MS;
  localparam int SLEEP_LOW_MS = 2000;
  localparam int SLEEP_LOW_CYCLES = CLK_KHZ * SLEEP_LOW_MS;
  localparam int DIV_W = 30;

  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_SPECIAL = 8'h08;
  localparam logic [7:0] IDX_CURRENT = 8'h0E;
  localparam logic [7:0] IDX_ACCUM = 8'h10;
  localparam logic [7:0] IDX_ADDR_LO = 8'h20;
  localparam logic [7:0] IDX_ADDR_HI = 8'h21;
  localparam logic [7:0] IDX_MODE = 8'h22;

  // Field positions
  localparam int BIT_SLEEP_ALLOW = 6;
  localparam int BIT_NET_OPCODE = 4;
  localparam int BIT_PIO_CTL = 6;
  localparam int BIT_MODE_ACTIVE = 0;
  localparam int BIT_MODE_OVD = 1;

  // Reset values
  localparam logic SLEEP_ALLOW_RST = 1'b0;
  localparam logic NET_OPCODE_RST = 1'b0;
  localparam logic PIO_CTL_RST = 1'b1;

  // Current and accumulator formats
  localparam logic [15:0] CUR_MAX_HI = 16'h7FFF;
  localparam logic [15:0] CUR_MAX_LO = 16'h1FFF;
  localparam int ACC_FRAC = 12;
  localparam int ACC_W = 16 + ACC_FRAC;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    CCP_SLEEP = 1'b0,
    CCP_ACTIVE = 1'b1
  } ccp_mode_t;
endpackage

// ### verilog/ccp_tick_div.sv
// Purpose: Cycle divider giving a one-cycle tick every PERIOD enabled cycles
// Assumes: Single clock, synchronous active-low reset
// Notes: clr restarts the count from zero and wins over counting
`timescale 1ns/1ps
module ccp_tick_div
  import ccp_pkg::*;
#(
  parameter int PERIOD = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  input wire logic run,
  output logic tick
);
  logic [DIV_W-1:0] cnt_r;
  wire last_w = (cnt_r == DIV_W'(PERIOD - 1));

  assign tick = run && !clr && last_w;

  // Restart on clear so a partial count never leaks into the next interval
  always_ff @(posedge aclk) begin
    if (!aresetn || clr || tick) begin
      cnt_r <= '0;
    end else if (run) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule
